// ---- shared/wesl_pkg.sv ----
// Constants for the low wake event status block
package wesl_pkg;
  // System clock
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Register byte offsets
  localparam logic [7:0] STS_OFS = 8'h00;
  localparam logic [7:0] EN_OFS = 8'h04;
  localparam logic [7:0] CTRL_OFS = 8'h08;
  localparam logic [7:0] MASK_OFS = 8'h0C;
  // Status and enable bit positions
  localparam int unsigned CODEC_BIT = 5;
  localparam int unsigned USB_BIT = 3;
  localparam int unsigned POL_BIT = 2;
  localparam int unsigned OVR_BIT = 1;
  localparam int unsigned THERM_BIT = 0;
  // Control bit positions
  localparam int unsigned ROUTE_BIT = 0;
  // Implemented bits
  localparam logic [7:0] STS_IMPL = 8'h2B;
  localparam logic [7:0] EN_IMPL = 8'h2D;
  localparam logic [7:0] CTRL_IMPL = 8'h01;
  // Reset values
  localparam logic [7:0] STS_RST = 8'h00;
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  // Bit clock silence before it counts as stopped
  localparam int unsigned BCLK_STALL_NS = 1000;
  localparam logic [7:0] BCLK_STALL_CYC =
    8'((BCLK_STALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

// ---- sim/testbench.sv ----
// Self-checking bench for the low wake event status block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_i = 0, rst_i = 1, rsmrst_i = 1, rtc_rst_i = 1; // Clock, resets
  logic cyc_i = 0, stb_i = 0, we_i = 0; // Bus strobes
  logic [7:0] adr_i = 8'h00; // Byte address
  logic [3:0] sel_i = 4'hF; // All lanes on
  logic [3:0] lanes = 4'hF; // Lanes for the next request
  logic [31:0] dat_i = 32'h0, dat_o, q; // Bus data, last read
  logic ack_o, wake_event_o, sci_o, system_mgmt_irq_o, irq_o; // Outputs
  logic [1:0] codec_serial_in_i; // From codec model
  logic codec_bit_clock_i, codec_wake = 0; // Codec link
  logic codec_global_irq_flag_i = 0, usb_wake_req_i = 0; // Events
  // Thermal pin idles high: inactive for the reset polarity
  logic thermal_override_start_i = 0, thermal_alarm_pin_i = 1;
  logic working_i = 1; // System awake
  int n_errors = 0, comparisons = 0, cycles = 0; // Tallies
  typedef struct {logic w; logic [7:0] a, d, e;} wesl_row_t;
  // Reset values, access kinds, unmapped place, write-ones on status;
  // the enable write keeps polarity low so the idle pin stays quiet
  wesl_row_t rows[14] = '{'{0, 8'h00, 8'h00, 8'h00},
    '{0, 8'h04, 8'h00, 8'h00}, '{0, 8'h08, 8'h00, 8'h00},
    '{0, 8'h0C, 8'h00, 8'h00}, '{1, 8'h04, 8'hFB, 8'h00},
    '{0, 8'h04, 8'h00, 8'h29}, '{1, 8'h08, 8'hFF, 8'h00},
    '{0, 8'h08, 8'h00, 8'h01}, '{1, 8'h0C, 8'hFF, 8'h00},
    '{0, 8'h0C, 8'h00, 8'h2B}, '{1, 8'h10, 8'hFF, 8'h00},
    '{0, 8'h10, 8'h00, 8'h00}, '{1, 8'h00, 8'hFF, 8'h00},
    '{0, 8'h00, 8'h00, 8'h00}};
  always #25 clk_i = ~clk_i;
  wesl_top i_wesl_top (.clk_i, .rst_i, .rsmrst_i, .rtc_rst_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .codec_serial_in_i,
    .codec_bit_clock_i, .codec_global_irq_flag_i, .usb_wake_req_i,
    .thermal_override_start_i, .thermal_alarm_pin_i, .working_i,
    .wake_event_o, .sci_o, .system_mgmt_irq_o, .irq_o);
  wesl_codec_model u_codec (.wake_i(codec_wake),
    .bclk_o(codec_bit_clock_i), .sdin_o(codec_serial_in_i));
  task automatic chk(input logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One classic cycle; waits for ack however long it takes
  task automatic wb(input logic w, input logic [7:0] a, d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i} <= {2'b11, w};
    adr_i <= a;
    sel_i <= lanes;
    dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task automatic rc(input logic [7:0] a, e);
    wb(1'b0, a, 8'h00);
    chk(q, {24'h0, e});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic print_verdict;
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    tick(2);
    {rst_i, rsmrst_i, rtc_rst_i} <= 3'b000;
    foreach (rows[i]) begin
      wb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(q, {24'h0, rows[i].e});
    end
    // Write without the low lane must leave the register alone
    lanes = 4'hE;
    wb(1'b1, 8'h08, 8'h00);
    lanes = 4'hF;
    rc(8'h08, 8'h01);
    // USB request, then both routes and sleep
    usb_wake_req_i <= 1'b1;
    tick(1);
    usb_wake_req_i <= 1'b0;
    rc(8'h00, 8'h08);
    chk({wake_event_o, sci_o, system_mgmt_irq_o, irq_o}, 4'b1101);
    wb(1'b1, 8'h08, 8'h00);
    tick(2);
    chk({sci_o, system_mgmt_irq_o}, 2'b01);
    working_i <= 1'b0;
    tick(3);
    chk({wake_event_o, sci_o, system_mgmt_irq_o}, 3'b100);
    working_i <= 1'b1;
    wb(1'b1, 8'h00, 8'h00);
    rc(8'h00, 8'h08);
    // Request held across the clear: the set must win
    usb_wake_req_i <= 1'b1;
    wb(1'b1, 8'h00, 8'h08);
    usb_wake_req_i <= 1'b0;
    rc(8'h00, 8'h08);
    wb(1'b1, 8'h00, 8'h08);
    rc(8'h00, 8'h00);
    chk({wake_event_o, irq_o}, 2'b00);
    // Thermal pin in both polarities, routed to the mgmt irq side
    for (int p = 1; p >= 0; p--) begin
      wb(1'b1, 8'h04, {5'b00101, p[0], 2'b01});
      thermal_alarm_pin_i <= !p[0];
      tick(6);
      wb(1'b1, 8'h00, 8'h01);
      rc(8'h00, 8'h00);
      thermal_alarm_pin_i <= p[0];
      tick(6);
      rc(8'h00, 8'h01);
      chk({system_mgmt_irq_o, irq_o}, 2'b11);
      thermal_alarm_pin_i <= !p[0];
      tick(6);
      wb(1'b1, 8'h00, 8'h01);
      rc(8'h00, 8'h00);
    end
    // Override raises only the masked interrupt
    wb(1'b1, 8'h04, 8'h29);
    wb(1'b1, 8'h0C, 8'h02);
    thermal_override_start_i <= 1'b1;
    tick(1);
    thermal_override_start_i <= 1'b0;
    rc(8'h00, 8'h02);
    chk({wake_event_o, sci_o, system_mgmt_irq_o, irq_o}, 4'b0001);
    rsmrst_i <= 1'b1;
    tick(1);
    rsmrst_i <= 1'b0;
    rc(8'h00, 8'h00);
    // Codec wake by stopped link clock survives both resets
    wb(1'b1, 8'h04, 8'h20);
    codec_wake <= 1'b1;
    tick(40);
    rc(8'h00, 8'h20);
    chk(wake_event_o, 1'b1);
    codec_wake <= 1'b0;
    {rst_i, rsmrst_i} <= 2'b11;
    tick(2);
    {rst_i, rsmrst_i} <= 2'b00;
    rc(8'h00, 8'h20);
    chk(wake_event_o, 1'b0);
    wb(1'b1, 8'h00, 8'h20);
    rc(8'h00, 8'h00);
    codec_global_irq_flag_i <= 1'b1;
    tick(1);
    codec_global_irq_flag_i <= 1'b0;
    rc(8'h00, 8'h20);
    print_verdict();
  end
endmodule
`default_nettype wire

// ---- sim/wesl_codec_model.sv ----
// Behavioural codec on the far side of the audio link
`timescale 1ns/10ps
`default_nettype none
module wesl_codec_model (
  input wire logic wake_i,
  output logic bclk_o,
  output logic [1:0] sdin_o
);
  initial bclk_o = 1'b0;
  // Link clock free-runs slow enough for the pin filter; stops to wake
  always #130 if (!wake_i) bclk_o = ~bclk_o;
  // Data high while clocked must not count as a wake request
  assign sdin_o = wake_i ? 2'b01 : 2'b10;
endmodule
`default_nettype wire

// ---- sim/wesl_props.sv ----
// Concurrent checks on the wake status block ports
`timescale 1ns/10ps
`default_nettype none
module wesl_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rsmrst_i,
  input wire logic rtc_rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic usb_wake_req_i,
  input wire logic codec_global_irq_flag_i,
  input wire logic working_i,
  input wire logic wake_event_o,
  input wire logic sci_o,
  input wire logic system_mgmt_irq_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rd_q; // Status read taken at the last edge
  // Marks the cycle whose read data is the status byte
  always_ff @(posedge clk_i) begin
    rd_q <= cyc_i & stb_i & ~we_i & ~ack_o & (adr_i == wesl_pkg::STS_OFS);
  end
  sequence s_req; cyc_i && stb_i && !ack_o; endsequence
  sequence s_sts; ack_o && rd_q; endsequence
  property p_ack; s_req |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("request not acked");
  property p_pulse; ack_o |=> !ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack held too long");
  property p_idle; !ack_o |-> dat_o == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside ack");
  property p_rsv;
    ack_o |-> dat_o[31:8] == 24'h0 && !(rd_q && (dat_o[4] || dat_o[2]));
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  // Flag must be visible in a status read acked two or three cycles on
  property p_usb;
    (usb_wake_req_i && !rsmrst_i) ##1 !rsmrst_i ##[1:2] s_sts |-> dat_o[3];
  endproperty
  a_usb: assert property (p_usb) else $error("usb flag missing");
  property p_codec_global_irq_flag;
    (codec_global_irq_flag_i && !rtc_rst_i) ##1 !rtc_rst_i ##[1:2] s_sts
      |-> dat_o[5];
  endproperty
  a_codec_global_irq_flag: assert property (p_codec_global_irq_flag) else $error("codec flag missing");
  property p_excl; !(sci_o && system_mgmt_irq_o); endproperty
  a_excl: assert property (p_excl) else $error("both routes high");
  property p_sleep; !working_i [*2] |-> !sci_o && !system_mgmt_irq_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("event asleep");
  // Ack, irq, wake event and SCI outputs start from zero after a hard reset
  property p_rst;
    $past(rst_i) |-> !ack_o && !irq_o && !wake_event_o && !sci_o;
  endproperty
  a_rst: assert property (p_rst) else $error("output high after reset");
endmodule
bind wesl_top wesl_props i_props (.clk_i, .rst_i, .rsmrst_i, .rtc_rst_i,
  .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .usb_wake_req_i,
  .codec_global_irq_flag_i, .working_i, .wake_event_o, .sci_o,
  .system_mgmt_irq_o, .irq_o);
`default_nettype wire

// ---- verilog/wesl_clk_watch.sv ----
// Detects a stopped codec bit clock
`timescale 1ns/10ps
`default_nettype none
module wesl_clk_watch (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bclk_i,
  output logic stalled_o
);
  logic prev_reg; // Last sampled clock level
  logic [7:0] cnt_reg; // Cycles since last edge
  // Remember previous level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= bclk_i;
    end
  end
  // Count quiet cycles, saturating at the stall limit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 8'h00;
    end else if (bclk_i != prev_reg) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg != wesl_pkg::BCLK_STALL_CYC) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
  // Stopped once the limit is reached
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stalled_o <= 1'b0;
    end else begin
      stalled_o <= (cnt_reg == wesl_pkg::BCLK_STALL_CYC);
    end
  end
endmodule
`default_nettype wire

// ---- verilog/wesl_sync3.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module wesl_sync3 #(
  parameter int unsigned WIDTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] ff1_reg; // Metastable stage, read by ff2 only
  logic [WIDTH-1:0] ff2_reg; // Second stage
  logic [WIDTH-1:0] ff3_reg; // Third stage
  // Shift chain
  always_ff @(posedge clk_i) begin
    ff1_reg <= d_i;
    ff2_reg <= ff1_reg;
    ff3_reg <= ff2_reg;
  end
  // Output moves only where stages two and three agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          q_o[g] <= 1'b0;
        end else if (ff2_reg[g] == ff3_reg[g]) begin
          q_o[g] <= ff3_reg[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- verilog/wesl_top.sv ----
// Low wake event status bits with Wishbone access
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module wesl_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rsmrst_i,
  input wire logic rtc_rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [1:0] codec_serial_in_i,
  input wire logic codec_bit_clock_i,
  input wire logic codec_global_irq_flag_i,
  input wire logic usb_wake_req_i,
  input wire logic thermal_override_start_i,
  input wire logic thermal_alarm_pin_i,
  input wire logic working_i,
  output logic wake_event_o,
  output logic sci_o,
  output logic system_mgmt_irq_o,
  output logic irq_o
);

  // Offset match, shared by read and write decode
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Synchronised pins
  logic [3:0] pins_sync;
  logic [1:0] sdin_sync; // Codec serial inputs
  logic bclk_sync; // Codec bit clock level
  logic therm_sync; // Thermal alarm level
  logic bclk_stalled; // Bit clock not toggling

  // Bus handshake
  logic req; // Live request
  logic wr_fire; // Write takes effect
  logic ack_next;

  // Registers, status image and clear mask
  logic codec_wake_flag_reg; // Survives power loss
  logic usb_wake_flag_reg;
  logic thermal_override_flag_reg;
  logic thermal_flag_reg;
  logic [7:0] en_reg; // Enables and polarity
  logic [7:0] ctrl_reg; // Routing control
  logic [7:0] mask_reg; // Interrupt mask
  logic [7:0] sts; // Assembled status
  logic [7:0] clr; // Write-one-to-clear bits

  // Set conditions
  logic codec_set;
  logic usb_set;
  logic ovr_set;
  logic therm_set;
  logic therm_active;
  logic [2:0] pins_ok_reg; // Sync chain refilled since core reset

  // Event terms
  logic wake_next;
  logic pm_event;
  logic [31:0] rd_next;

  // Pin inputs cross in here
  wesl_sync3 #(
    .WIDTH(4)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({thermal_alarm_pin_i, codec_bit_clock_i,
          codec_serial_in_i}),
    .q_o(pins_sync)
  );

  assign sdin_sync = pins_sync[1:0];
  assign bclk_sync = pins_sync[2];
  assign therm_sync = pins_sync[3];

  // Watches for a silent bit clock
  wesl_clk_watch u_watch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bclk_i(bclk_sync),
    .stalled_o(bclk_stalled)
  );

  // The thermal pin level counts only once the sync chain has refilled after a
  // core reset; the cleared stage can look like an active thermal pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_ok_reg <= 3'b000;
    end else begin
      pins_ok_reg <= {pins_ok_reg[1:0], 1'b1};
    end
  end

  // Bus request decode
  always_comb begin
    req = cyc_i & stb_i;
    // Write lands on the edge where the master sees ack
    wr_fire = req & we_i & ack_o & sel_i[0];
    ack_next = req & ~ack_o;
  end

  // Acknowledge one cycle after request, then drop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= ack_next;
    end
  end

  // Clear mask from a status write
  always_comb begin
    if (wr_fire && hit(adr_i, wesl_pkg::STS_OFS)) begin
      clr = dat_i[7:0] & wesl_pkg::STS_IMPL;
    end else begin
      clr = 8'h00;
    end
  end

  // Set conditions
  always_comb begin
    // Either data line high with clock stopped, or codec irq
    codec_set = ((|sdin_sync) & bclk_stalled)
                | codec_global_irq_flag_i;
    usb_set = usb_wake_req_i;
    ovr_set = thermal_override_start_i;
    // Polarity bit picks the active pin level
    therm_active =
      (therm_sync == en_reg[wesl_pkg::POL_BIT]);
    therm_set = therm_active & pins_ok_reg[2];
  end

  // Codec flag: of the resets only the battery-backed one clears it
  // A hard reset on rst_i must not touch it
  always_ff @(posedge clk_i) begin
    if (rtc_rst_i) begin
      codec_wake_flag_reg <= 1'b0;
    end else begin
      // Set wins over a simultaneous clear
      codec_wake_flag_reg <= codec_set
        | (codec_wake_flag_reg
           & ~clr[wesl_pkg::CODEC_BIT]);
    end
  end

  // USB flag, resume well
  always_ff @(posedge clk_i) begin
    if (rsmrst_i) begin
      usb_wake_flag_reg <= 1'b0;
    end else begin
      usb_wake_flag_reg <= usb_set
        | (usb_wake_flag_reg
           & ~clr[wesl_pkg::USB_BIT]);
    end
  end

  // Thermal override flag, resume well
  always_ff @(posedge clk_i) begin
    if (rsmrst_i) begin
      thermal_override_flag_reg <= 1'b0;
    end else begin
      thermal_override_flag_reg <= ovr_set
        | (thermal_override_flag_reg
           & ~clr[wesl_pkg::OVR_BIT]);
    end
  end

  // Thermal flag; a held active pin keeps re-setting it
  always_ff @(posedge clk_i) begin
    if (rsmrst_i) begin
      thermal_flag_reg <= 1'b0;
    end else begin
      thermal_flag_reg <= therm_set
        | (thermal_flag_reg
           & ~clr[wesl_pkg::THERM_BIT]);
    end
  end

  // Enable register lives in the resume well
  always_ff @(posedge clk_i) begin
    if (rsmrst_i) begin
      en_reg <= wesl_pkg::EN_RST;
    end else if (wr_fire && hit(adr_i, wesl_pkg::EN_OFS)) begin
      en_reg <= dat_i[7:0] & wesl_pkg::EN_IMPL;
    end
  end

  // Routing control, core well
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= wesl_pkg::CTRL_RST;
    end else if (wr_fire && hit(adr_i, wesl_pkg::CTRL_OFS)) begin
      ctrl_reg <= dat_i[7:0] & wesl_pkg::CTRL_IMPL;
    end
  end

  // Interrupt mask, same layout as status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_reg <= wesl_pkg::MASK_RST;
    end else if (wr_fire && hit(adr_i, wesl_pkg::MASK_OFS)) begin
      mask_reg <= dat_i[7:0] & wesl_pkg::STS_IMPL;
    end
  end

  // Status image; reserved bits tie low
  always_comb begin
    sts = 8'h00;
    sts[wesl_pkg::CODEC_BIT] = codec_wake_flag_reg;
    sts[wesl_pkg::USB_BIT] = usb_wake_flag_reg;
    sts[wesl_pkg::OVR_BIT] = thermal_override_flag_reg;
    sts[wesl_pkg::THERM_BIT] = thermal_flag_reg;
  end

  // Event terms; the override flag has no enable by design
  always_comb begin
    wake_next =
      (codec_wake_flag_reg & en_reg[wesl_pkg::CODEC_BIT])
      | (usb_wake_flag_reg & en_reg[wesl_pkg::USB_BIT]);
    // Override flag stays out of every event term
    pm_event = wake_next
      | (thermal_flag_reg
         & en_reg[wesl_pkg::THERM_BIT]);
  end

  // Wake event level output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_event_o <= 1'b0;
    end else begin
      wake_event_o <= wake_next;
    end
  end

  // SCI in working state with routing select set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sci_o <= 1'b0;
    end else begin
      sci_o <= pm_event & working_i
               & ctrl_reg[wesl_pkg::ROUTE_BIT];
    end
  end

  // Mgmt irq in working state with routing select clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      system_mgmt_irq_o <= 1'b0;
    end else begin
      system_mgmt_irq_o <= pm_event & working_i
                           & ~ctrl_reg[wesl_pkg::ROUTE_BIT];
    end
  end

  // Block interrupt: any unmasked status bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(sts & mask_reg);
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_next = 32'h0000_0000;
    if (hit(adr_i, wesl_pkg::STS_OFS)) begin
      rd_next[7:0] = sts;
    end else if (hit(adr_i, wesl_pkg::EN_OFS)) begin
      rd_next[7:0] = en_reg;
    end else if (hit(adr_i, wesl_pkg::CTRL_OFS)) begin
      rd_next[7:0] = ctrl_reg;
    end else if (hit(adr_i, wesl_pkg::MASK_OFS)) begin
      rd_next[7:0] = mask_reg;
    end
  end

  // Read data captured as ack rises
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (ack_next && !we_i) begin
      dat_o <= rd_next;
    end else begin
      dat_o <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire
